// >>> hdl/bbce_consts.svh
`ifndef BBCE_CONSTS_SVH
`define BBCE_CONSTS_SVH

// ****************************************************************
// Opcodes
// ****************************************************************
`define BBCE_OP_SOFT_INT 8'h00
`define BBCE_OP_CLR_BIT 8'h14
`define BBCE_OP_CLR_CARRY 8'h18
`define BBCE_OP_BR_MINUS 8'h30
`define BBCE_OP_BR_NOT_EQ 8'hd0
`define BBCE_OP_BR_PLUS 8'h10
`define BBCE_OP_BR_ALWAYS 8'h80
`define BBCE_OP_BR_OVF_CLR 8'h50
`define BBCE_OP_BR_OVF_SET 8'h70

// ****************************************************************
// Least cycle counts per instruction
// ****************************************************************
`define BBCE_CYC_SOFT_INT 5'h0f
`define BBCE_CYC_CLR_BIT 5'h08
`define BBCE_CYC_CLR_CARRY 5'h02
`define BBCE_CYC_NONE 5'h01

// ****************************************************************
// Byte lengths
// ****************************************************************
`define BBCE_LEN_SOFT_INT 16'h0002
`define BBCE_LEN_CLR_BIT 16'h0003
`define BBCE_LEN_CLR_CARRY 16'h0001
`define BBCE_LEN_BRANCH 16'h0002

// ****************************************************************
// Status flag positions
// ****************************************************************
`define BBCE_PS_C 0
`define BBCE_PS_Z 1
`define BBCE_PS_I 2
`define BBCE_PS_V 6
`define BBCE_PS_N 7

// ****************************************************************
// Software interrupt vector and bank reload
// ****************************************************************
`define BBCE_VEC_SOFT_INT 16'hfff4
`define BBCE_BANK_AFTER_INT 8'h00
`define BBCE_DATA_BANK 8'h00

// ****************************************************************
// Register port indices and reset values
// ****************************************************************
`define BBCE_REG_CTRL 4'h0
`define BBCE_REG_STAT 4'h1
`define BBCE_REG_PC 4'h2
`define BBCE_REG_PG 4'h3
`define BBCE_REG_SP 4'h4
`define BBCE_REG_PS 4'h5
`define BBCE_RST_PC 16'h0000
`define BBCE_RST_PG 8'h00
`define BBCE_RST_SP 16'h01ff
`define BBCE_RST_PS 16'h0004
`define BBCE_PUSH_LAST 3'h4

`endif

// >>> hdl/bbce_pkg.sv
package bbce_pkg;
    typedef enum logic [3:0] {
        BBCE_S_HALT,
        BBCE_S_FETCH,
        BBCE_S_RDWAIT,
        BBCE_S_DECODE,
        BBCE_S_OPR1,
        BBCE_S_OPR2,
        BBCE_S_CLB_WR,
        BBCE_S_PUSH,
        BBCE_S_VEC,
        BBCE_S_VEC_LO,
        BBCE_S_VEC_HI,
        BBCE_S_PAD
    } bbce_state_t;
    typedef logic [15:0] bbce_word_t;
    typedef logic [7:0] bbce_byte_t;
    typedef logic [23:0] bbce_addr_t;
endpackage

// >>> hdl/bbce_br_if.sv
`timescale 1ns/100ps
`default_nettype none
interface bbce_br_if;
    logic [7:0] opcode;
    logic [15:0] flags;
    logic [15:0] pc;
    logic [7:0] pg;
    logic [7:0] offset;
    logic is_branch;
    logic taken;
    logic [15:0] new_pc;
    logic [7:0] new_pg;
    modport core (
        output opcode,
        output flags,
        output pc,
        output pg,
        output offset,
        input is_branch,
        input taken,
        input new_pc,
        input new_pg
    );
    modport unit (
        input opcode,
        input flags,
        input pc,
        input pg,
        input offset,
        output is_branch,
        output taken,
        output new_pc,
        output new_pg
    );
endinterface
`default_nettype wire

// >>> hdl/bbce_branch_unit.sv
`timescale 1ns/100ps
`default_nettype none
`include "bbce_consts.svh"
module bbce_branch_unit (
    bbce_br_if.unit br
);
    import bbce_pkg::*;

    logic [15:0] pc_after;
    logic [17:0] sum;

    always_comb begin
        br.is_branch = 1'b1;
        br.taken = 1'b0;
        case (br.opcode)
            `BBCE_OP_BR_MINUS: br.taken = br.flags[`BBCE_PS_N];
            `BBCE_OP_BR_NOT_EQ: br.taken = !br.flags[`BBCE_PS_Z];
            `BBCE_OP_BR_PLUS: br.taken = !br.flags[`BBCE_PS_N];
            `BBCE_OP_BR_ALWAYS: br.taken = 1'b1;
            `BBCE_OP_BR_OVF_CLR: br.taken = !br.flags[`BBCE_PS_V];
            `BBCE_OP_BR_OVF_SET: br.taken = br.flags[`BBCE_PS_V];
            default: br.is_branch = 1'b0;
        endcase
    end

    // Offset is relative to the byte after the operand; bit 17 marks borrow, bit 16 carry
    always_comb begin
        pc_after = br.pc + `BBCE_LEN_BRANCH;
        sum = {2'b00, pc_after} + {{10{br.offset[7]}}, br.offset};
        br.new_pc = sum[15:0];
        br.new_pg = br.pg;
        if (!br.taken) begin
            br.new_pc = pc_after;
        end else if (sum[17]) begin
            br.new_pg = br.pg - 8'h01;
        end else if (sum[16]) begin
            br.new_pg = br.pg + 8'h01;
        end
    end
endmodule
`default_nettype wire

// >>> hdl/bbce_core.sv
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "bbce_consts.svh"
module bbce_core (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic [3:0] i_reg_addr,
    input wire logic [15:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [15:0] o_reg_rdata,
    output bbce_pkg::bbce_addr_t o_mem_addr,
    output logic o_mem_rd,
    output logic o_mem_wr,
    output bbce_pkg::bbce_byte_t o_mem_wdata,
    input wire logic [7:0] i_mem_rdata,
    output bbce_pkg::bbce_word_t o_pc,
    output bbce_pkg::bbce_byte_t o_pg,
    output bbce_pkg::bbce_word_t o_sp,
    output bbce_pkg::bbce_word_t o_ps,
    output logic o_halted
);
    import bbce_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    bbce_state_t state_reg;
    bbce_state_t ret_reg;
    bbce_word_t pc_reg;
    bbce_byte_t pg_reg;
    bbce_word_t sp_reg;
    bbce_word_t ps_reg;
    bbce_byte_t op_reg;
    bbce_byte_t opr1_reg;
    bbce_byte_t mask_reg;
    logic [2:0] push_idx_reg;
    logic [4:0] cyc_reg;
    logic [4:0] target_reg;
    logic run_reg;
    logic [15:0] rdata_reg;
    bbce_addr_t mem_addr_reg;
    logic mem_rd_reg;
    logic mem_wr_reg;
    bbce_byte_t mem_wdata_reg;
    logic dbg_wr;
    bbce_byte_t push_byte;
    logic [4:0] cyc_next;

    bbce_br_if br ();

    assign br.opcode = op_reg;
    assign br.flags = ps_reg;
    assign br.pc = pc_reg;
    assign br.pg = pg_reg;
    assign br.offset = i_mem_rdata;

    bbce_branch_unit u_branch (
        .br(br)
    );

    // Finish when the least count has elapsed, else pad
    function automatic bbce_state_t done_or_pad(input logic [4:0] cyc, input logic [4:0] target);
        done_or_pad = (cyc >= target) ? BBCE_S_FETCH : BBCE_S_PAD;
    endfunction

    function automatic bbce_addr_t data_addr(input bbce_word_t a);
        data_addr = {`BBCE_DATA_BANK, a};
    endfunction

    // Debug writes only land while halted so they cannot tear an instruction
    assign dbg_wr = i_reg_wr && (state_reg == BBCE_S_HALT);
    assign cyc_next = cyc_reg + 5'h01;

    // ****************************************************************
    // Push byte order
    // ****************************************************************
    always_comb begin
        case (push_idx_reg)
            3'h0: push_byte = pg_reg;
            3'h1: push_byte = pc_reg[15:8];
            3'h2: push_byte = pc_reg[7:0];
            3'h3: push_byte = ps_reg[15:8];
            default: push_byte = ps_reg[7:0];
        endcase
    end

    // ****************************************************************
    // Sequencer and memory strobes
    // ****************************************************************
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state_reg <= BBCE_S_HALT;
            ret_reg <= BBCE_S_HALT;
            op_reg <= 8'h00;
            opr1_reg <= 8'h00;
            mask_reg <= 8'h00;
            push_idx_reg <= 3'h0;
            cyc_reg <= 5'h00;
            target_reg <= `BBCE_CYC_NONE;
            mem_addr_reg <= 24'h000000;
            mem_rd_reg <= 1'b0;
            mem_wr_reg <= 1'b0;
            mem_wdata_reg <= 8'h00;
        end else begin
            mem_rd_reg <= 1'b0;
            mem_wr_reg <= 1'b0;
            cyc_reg <= cyc_next;
            case (state_reg)
                BBCE_S_HALT: begin
                    if (run_reg) begin
                        state_reg <= BBCE_S_FETCH;
                    end
                end
                BBCE_S_FETCH: begin
                    if (!run_reg) begin
                        state_reg <= BBCE_S_HALT;
                    end else begin
                        cyc_reg <= 5'h02;
                        mem_addr_reg <= {pg_reg, pc_reg};
                        mem_rd_reg <= 1'b1;
                        ret_reg <= BBCE_S_DECODE;
                        state_reg <= BBCE_S_RDWAIT;
                    end
                end
                BBCE_S_RDWAIT: begin
                    state_reg <= ret_reg;
                end
                BBCE_S_DECODE: begin
                    op_reg <= i_mem_rdata;
                    if (i_mem_rdata == `BBCE_OP_CLR_CARRY) begin
                        target_reg <= `BBCE_CYC_CLR_CARRY;
                        state_reg <= done_or_pad(cyc_reg, `BBCE_CYC_CLR_CARRY);
                    end else if (i_mem_rdata == `BBCE_OP_SOFT_INT || i_mem_rdata == `BBCE_OP_CLR_BIT ||
                                 i_mem_rdata == `BBCE_OP_BR_MINUS || i_mem_rdata == `BBCE_OP_BR_NOT_EQ ||
                                 i_mem_rdata == `BBCE_OP_BR_PLUS || i_mem_rdata == `BBCE_OP_BR_ALWAYS ||
                                 i_mem_rdata == `BBCE_OP_BR_OVF_CLR || i_mem_rdata == `BBCE_OP_BR_OVF_SET) begin
                        mem_addr_reg <= {pg_reg, pc_reg + 16'h0001};
                        mem_rd_reg <= 1'b1;
                        ret_reg <= BBCE_S_OPR1;
                        state_reg <= BBCE_S_RDWAIT;
                    end else begin
                        // Unknown codes pass as one-byte no-ops
                        target_reg <= `BBCE_CYC_NONE;
                        state_reg <= BBCE_S_FETCH;
                    end
                end
                BBCE_S_OPR1: begin
                    opr1_reg <= i_mem_rdata;
                    if (op_reg == `BBCE_OP_SOFT_INT) begin
                        push_idx_reg <= 3'h0;
                        target_reg <= `BBCE_CYC_SOFT_INT;
                        state_reg <= BBCE_S_PUSH;
                    end else if (op_reg == `BBCE_OP_CLR_BIT) begin
                        mem_addr_reg <= {pg_reg, pc_reg + 16'h0002};
                        mem_rd_reg <= 1'b1;
                        ret_reg <= BBCE_S_OPR2;
                        target_reg <= `BBCE_CYC_CLR_BIT;
                        state_reg <= BBCE_S_RDWAIT;
                    end else begin
                        target_reg <= `BBCE_CYC_NONE;
                        state_reg <= BBCE_S_FETCH;
                    end
                end
                BBCE_S_OPR2: begin
                    mask_reg <= i_mem_rdata;
                    mem_addr_reg <= data_addr({8'h00, opr1_reg});
                    mem_rd_reg <= 1'b1;
                    ret_reg <= BBCE_S_CLB_WR;
                    state_reg <= BBCE_S_RDWAIT;
                end
                BBCE_S_CLB_WR: begin
                    mem_wdata_reg <= i_mem_rdata & ~mask_reg;
                    mem_wr_reg <= 1'b1;
                    state_reg <= done_or_pad(cyc_reg, target_reg);
                end
                BBCE_S_PUSH: begin
                    mem_addr_reg <= data_addr(sp_reg);
                    mem_wdata_reg <= push_byte;
                    mem_wr_reg <= 1'b1;
                    push_idx_reg <= push_idx_reg + 3'h1;
                    if (push_idx_reg == `BBCE_PUSH_LAST) begin
                        state_reg <= BBCE_S_VEC;
                    end
                end
                BBCE_S_VEC: begin
                    mem_addr_reg <= data_addr(`BBCE_VEC_SOFT_INT);
                    mem_rd_reg <= 1'b1;
                    ret_reg <= BBCE_S_VEC_LO;
                    state_reg <= BBCE_S_RDWAIT;
                end
                BBCE_S_VEC_LO: begin
                    mem_addr_reg <= data_addr(`BBCE_VEC_SOFT_INT + 16'h0001);
                    mem_rd_reg <= 1'b1;
                    ret_reg <= BBCE_S_VEC_HI;
                    state_reg <= BBCE_S_RDWAIT;
                end
                BBCE_S_VEC_HI: begin
                    state_reg <= done_or_pad(cyc_reg, target_reg);
                end
                BBCE_S_PAD: begin
                    state_reg <= done_or_pad(cyc_reg, target_reg);
                end
                default: begin
                    state_reg <= BBCE_S_HALT;
                end
            endcase
        end
    end

    // ****************************************************************
    // Program counter and bank
    // ****************************************************************
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            pc_reg <= `BBCE_RST_PC;
            pg_reg <= `BBCE_RST_PG;
        end else if (dbg_wr && i_reg_addr == `BBCE_REG_PC) begin
            pc_reg <= i_reg_wdata;
        end else if (dbg_wr && i_reg_addr == `BBCE_REG_PG) begin
            pg_reg <= i_reg_wdata[7:0];
        end else begin
            case (state_reg)
                BBCE_S_DECODE: begin
                    if (i_mem_rdata == `BBCE_OP_CLR_CARRY) begin
                        pc_reg <= pc_reg + `BBCE_LEN_CLR_CARRY;
                    end else if (!(i_mem_rdata == `BBCE_OP_SOFT_INT || i_mem_rdata == `BBCE_OP_CLR_BIT ||
                                   i_mem_rdata == `BBCE_OP_BR_MINUS || i_mem_rdata == `BBCE_OP_BR_NOT_EQ ||
                                   i_mem_rdata == `BBCE_OP_BR_PLUS || i_mem_rdata == `BBCE_OP_BR_ALWAYS ||
                                   i_mem_rdata == `BBCE_OP_BR_OVF_CLR || i_mem_rdata == `BBCE_OP_BR_OVF_SET)) begin
                        pc_reg <= pc_reg + 16'h0001;
                    end
                end
                BBCE_S_OPR1: begin
                    if (op_reg == `BBCE_OP_SOFT_INT) begin
                        pc_reg <= pc_reg + `BBCE_LEN_SOFT_INT;
                    end else if (br.is_branch) begin
                        pc_reg <= br.new_pc;
                        pg_reg <= br.new_pg;
                    end
                end
                BBCE_S_CLB_WR: begin
                    pc_reg <= pc_reg + `BBCE_LEN_CLR_BIT;
                end
                BBCE_S_VEC_LO: begin
                    pc_reg[7:0] <= i_mem_rdata;
                end
                BBCE_S_VEC_HI: begin
                    pc_reg[15:8] <= i_mem_rdata;
                    pg_reg <= `BBCE_BANK_AFTER_INT;
                end
                default: begin
                end
            endcase
        end
    end

    // ****************************************************************
    // Stack pointer
    // ****************************************************************
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            sp_reg <= `BBCE_RST_SP;
        end else if (dbg_wr && i_reg_addr == `BBCE_REG_SP) begin
            sp_reg <= i_reg_wdata;
        end else if (state_reg == BBCE_S_PUSH) begin
            sp_reg <= sp_reg - 16'h0001;
        end
    end

    // ****************************************************************
    // Processor status
    // ****************************************************************
    // Branches never touch this register, taken or not
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            ps_reg <= `BBCE_RST_PS;
        end else if (dbg_wr && i_reg_addr == `BBCE_REG_PS) begin
            ps_reg <= i_reg_wdata;
        end else if (state_reg == BBCE_S_DECODE && i_mem_rdata == `BBCE_OP_CLR_CARRY) begin
            ps_reg[`BBCE_PS_C] <= 1'b0;
        end else if (state_reg == BBCE_S_VEC) begin
            // Set only after the status byte has been pushed
            ps_reg[`BBCE_PS_I] <= 1'b1;
        end
    end

    // ****************************************************************
    // Register port
    // ****************************************************************
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            run_reg <= 1'b0;
        end else if (i_reg_wr && i_reg_addr == `BBCE_REG_CTRL) begin
            run_reg <= i_reg_wdata[0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            rdata_reg <= 16'h0000;
        end else if (i_reg_rd) begin
            if (i_reg_addr == `BBCE_REG_CTRL) begin
                rdata_reg <= {15'h0000, run_reg};
            end else if (i_reg_addr == `BBCE_REG_STAT) begin
                rdata_reg <= {op_reg, 7'h00, state_reg == BBCE_S_HALT};
            end else if (i_reg_addr == `BBCE_REG_PC) begin
                rdata_reg <= pc_reg;
            end else if (i_reg_addr == `BBCE_REG_PG) begin
                rdata_reg <= {8'h00, pg_reg};
            end else if (i_reg_addr == `BBCE_REG_SP) begin
                rdata_reg <= sp_reg;
            end else if (i_reg_addr == `BBCE_REG_PS) begin
                rdata_reg <= ps_reg;
            end else begin
                rdata_reg <= 16'h0000;
            end
        end else begin
            rdata_reg <= 16'h0000;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign o_reg_rdata = rdata_reg;
    assign o_mem_addr = mem_addr_reg;
    assign o_mem_rd = mem_rd_reg;
    assign o_mem_wr = mem_wr_reg;
    assign o_mem_wdata = mem_wdata_reg;
    assign o_pc = pc_reg;
    assign o_pg = pg_reg;
    assign o_sp = sp_reg;
    assign o_ps = ps_reg;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_halted <= 1'b1;
        end else begin
            o_halted <= (state_reg == BBCE_S_HALT);
        end
    end
endmodule
`default_nettype wire

// >>> tb/bbce_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module bbce_mem_model (
    input wire logic i_clk,
    input wire bbce_pkg::bbce_addr_t i_addr,
    input wire logic i_rd,
    input wire logic i_wr,
    input wire bbce_pkg::bbce_byte_t i_wdata,
    output bbce_pkg::bbce_byte_t o_rdata
);
    import bbce_pkg::*;
    // ****
    // Byte store, answer one cycle after the strobe
    // ****
    // Banks alias onto one store
    logic [7:0] mem [0:65535];
    initial o_rdata = 8'h00;
    always @(posedge i_clk) begin
        if (i_wr) begin
            mem[i_addr[15:0]] <= i_wdata;
        end
        // Idle bus inverts so a stale byte never passes
        o_rdata <= i_rd ? mem[i_addr[15:0]] : ~o_rdata;
    end
endmodule
`default_nettype wire

// >>> tb/bbce_core_sva.sv
`timescale 1ns/100ps
`default_nettype none
module bbce_core_sva (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_reg_rd,
    input wire logic [15:0] o_reg_rdata,
    input wire bbce_pkg::bbce_addr_t o_mem_addr,
    input wire logic o_mem_rd,
    input wire logic o_mem_wr,
    input wire bbce_pkg::bbce_byte_t o_mem_wdata,
    input wire logic [7:0] i_mem_rdata,
    input wire bbce_pkg::bbce_word_t o_pc,
    input wire bbce_pkg::bbce_byte_t o_pg,
    input wire bbce_pkg::bbce_word_t o_sp,
    input wire bbce_pkg::bbce_word_t o_ps
);
    import bbce_pkg::*;
    // ****
    // Opcode tracking
    // ****
    // A read at {bank,counter} is a fetch
    logic op_q;
    logic [7:0] off_q;
    bbce_word_t pc_q, sp_q, ps_q;
    bbce_byte_t pg_q;
    wire logic fetch = o_mem_rd && o_mem_addr == {o_pg, o_pc};
    wire bbce_word_t pc2 = pc_q + 16'h0002;
    wire logic [8:0] opc = {op_q, i_mem_rdata};
    always_ff @(posedge i_clk) begin
        op_q <= fetch && !i_srst;
        off_q <= i_mem_rdata;
    end
    always_ff @(posedge i_clk) begin
        if (fetch) begin
            pc_q <= o_pc;
            pg_q <= o_pg;
            sp_q <= o_sp;
            ps_q <= o_ps;
        end
    end
    function automatic logic taken(input logic [7:0] c, input bbce_word_t s);
        case (c)
            8'h30: return s[7];
            8'hd0: return !s[1];
            8'h10: return !s[7];
            8'h50: return !s[6];
            8'h70: return s[6];
            default: return 1'b1;
        endcase
    endfunction
    wire logic is_br = op_q && i_mem_rdata inside {8'h30, 8'hd0, 8'h10, 8'h50, 8'h70, 8'h80};
    wire logic take_now = taken(i_mem_rdata, o_ps);
    // ****
    // Properties
    // ****
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_srst);
    sequence s_push(logic [7:0] d, bbce_word_t a);
        o_mem_wr && o_mem_wdata == d && o_mem_addr == {8'h00, a};
    endsequence
    sequence s_brk_pushes;
        s_push(pg_q, sp_q) ##1 s_push(pc2[15:8], sp_q - 16'h0001) ##1 s_push(pc2[7:0], sp_q - 16'h0002)
            ##1 s_push(ps_q[15:8], sp_q - 16'h0003) ##1 s_push(ps_q[7:0], sp_q - 16'h0004);
    endsequence
    a_brk_push: assert property (
        opc == 9'h100 |-> ##4 s_brk_pushes)
        else $error("push order wrong");
    a_brk_vector: assert property (
        opc == 9'h100 |-> ##13 (o_pg == 8'h00 && o_ps[2] && o_sp == sp_q - 16'h0005))
        else $error("interrupt end wrong");
    a_branch_dest: assert property (
        is_br |-> ##3 {o_pg, o_pc} == ($past(take_now, 3) ? {pg_q, pc_q} + 24'h000002 + {{16{off_q[7]}}, off_q}
            : {pg_q, pc2}))
        else $error("branch target wrong");
    a_branch_flags: assert property (
        is_br |=> $stable(o_ps)[*3])
        else $error("branch moved flags");
    a_clc_clear: assert property (
        opc == 9'h118 |-> ##1 (o_ps == ($past(o_ps) & 16'hfffe) && o_pc == pc_q + 16'h0001))
        else $error("clear carry wrong");
    a_clc_next: assert property (
        opc == 9'h118 |-> !o_mem_rd ##1 !o_mem_rd ##1 (o_mem_rd && o_mem_addr == {pg_q, pc_q + 16'h0001}))
        else $error("clear carry timing");
    a_clb_write: assert property (
        opc == 9'h114 |-> ##7 (o_mem_wr && o_mem_wdata == ($past(i_mem_rdata) & ~$past(i_mem_rdata, 3))
            && o_mem_addr == {16'h0000, $past(i_mem_rdata, 5)}))
        else $error("bit clear write wrong");
    a_rdata_idle: assert property (
        !i_reg_rd |=> o_reg_rdata == 16'h0000)
        else $error("stale read data");
endmodule
bind bbce_core bbce_core_sva i_sva (.*);
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import bbce_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [3:0] ra = 4'h0;
    logic [15:0] wd = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] rdata;
    bbce_addr_t maddr;
    logic mrd, mwr, hl;
    bbce_byte_t mwd, mrdata, pg;
    bbce_word_t pc, sp, ps;
    int n_errors = 0;
    int compares = 0;
    logic [31:0] seed = 32'h00006c79;
    logic [7:0] ops [6] = '{8'h30, 8'hd0, 8'h10, 8'h50, 8'h70, 8'h80};
    bbce_core i_bbce_core (.i_clk(clk), .i_srst(srst), .i_reg_addr(ra), .i_reg_wdata(wd), .i_reg_wr(wr),
        .i_reg_rd(rd), .o_reg_rdata(rdata), .o_mem_addr(maddr), .o_mem_rd(mrd), .o_mem_wr(mwr),
        .o_mem_wdata(mwd), .i_mem_rdata(mrdata), .o_pc(pc), .o_pg(pg), .o_sp(sp), .o_ps(ps), .o_halted(hl));
    bbce_mem_model i_mem (.i_clk(clk), .i_addr(maddr), .i_rd(mrd), .i_wr(mwr), .i_wdata(mwd), .o_rdata(mrdata));
    initial begin
        forever #10 clk = ~clk;
    end
    // ****
    // Helpers
    // ****
    function logic [15:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[15:0];
    endfunction
    function logic tk(input bbce_byte_t op, input bbce_word_t s);
        case (op)
            8'h30: return s[7];
            8'hd0: return !s[1];
            8'h10: return !s[7];
            8'h50: return !s[6];
            8'h70: return s[6];
            default: return 1'b1;
        endcase
    endfunction
    function bbce_addr_t tgt(input bbce_byte_t g, input bbce_word_t p, input bbce_byte_t o);
        return {g, p} + 24'h000002 + {{16{o[7]}}, o};
    endfunction
    task chk(input logic [23:0] got, input logic [23:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wreg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        ra <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rreg(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        ra <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task poke(input bbce_word_t a, input bbce_byte_t d);
        i_mem.mem[a] = d;
    endtask
    // A self loop parks the core for sampling
    task lp(input bbce_word_t a);
        poke(a, 8'h80);
        poke(a + 16'h0001, 8'hfe);
    endtask
    // Halt first, or patching may tear a live loop
    task hold();
        wreg(4'h0, 16'h0000);
        repeat (20) @(posedge clk);
    endtask
    task run(input bbce_word_t p, input bbce_byte_t g, input bbce_word_t s, input bbce_word_t k);
        wreg(4'h2, p);
        wreg(4'h3, {8'h00, g});
        wreg(4'h4, k);
        wreg(4'h5, s);
        wreg(4'h0, 16'h0001);
        repeat (40) @(posedge clk);
        #1;
    endtask
    task edge_br(input bbce_word_t p, input bbce_byte_t g, input bbce_byte_t o);
        bbce_addr_t e;
        e = tgt(g, p, o);
        hold();
        poke(p, 8'h80);
        poke(p + 16'h0001, o);
        lp(e[15:0]);
        run(p, g, 16'h0004, 16'h01ff);
        chk({pg, pc}, e);
    endtask
    task give_verdict();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        give_verdict();
    end
    // ****
    // Scenarios
    // ****
    initial begin
        logic [15:0] v, s, r;
        logic [7:0] o, m;
        logic [7:0] st [5];
        bbce_addr_t e;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        rreg(4'h1, v);
        chk(v[0], 1'b1);
        chk(hl, 1'b1);
        rreg(4'h4, v);
        chk(v, 16'h01ff);
        rreg(4'h5, v);
        chk(v, 16'h0004);
        // Branches: flags clear, set, then random
        for (int i = 0; i < 24; i++) begin
            r = rnd();
            s = i < 6 ? 16'h0000 : i < 12 ? 16'h00c2 : rnd() & 16'h00c6;
            o = 8'h04 + {3'h0, r[12:8]};
            o = r[15] ? 8'h00 - o : o;
            e = tk(ops[i % 6], s) ? tgt(8'h01, 16'h4000, o) : 24'h014002;
            hold();
            poke(16'h4000, ops[i % 6]);
            poke(16'h4001, o);
            lp(16'h4002);
            lp(e[15:0]);
            run(16'h4000, 8'h01, s, 16'h01ff);
            chk({pg, pc}, e);
            chk(ps, s);
        end
        edge_br(16'hfff0, 8'h01, 8'h20);
        edge_br(16'h0004, 8'h02, 8'hf0);
        hold();
        poke(16'h40ff, 8'hea);
        poke(16'h4100, 8'h18);
        lp(16'h4101);
        run(16'h40ff, 8'h00, 16'h00c7, 16'h01ff);
        chk(ps, 16'h00c6);
        chk(pc, 16'h4101);
        for (int j = 0; j < 2; j++) begin
            r = rnd();
            m = j == 0 ? 8'hff : r[7:0];
            hold();
            poke(16'h4200, 8'h14);
            poke(16'h4201, 8'h40);
            poke(16'h4202, m);
            poke(16'h0040, r[15:8]);
            lp(16'h4203);
            run(16'h4200, 8'h00, 16'h0004, 16'h01ff);
            chk(i_mem.mem[16'h0040], r[15:8] & ~m);
            chk(pc, 16'h4203);
        end
        hold();
        poke(16'h4300, 8'h00);
        poke(16'h4301, 8'h55);
        poke(16'hfff4, 8'h00);
        poke(16'hfff5, 8'h45);
        lp(16'h4500);
        run(16'h4300, 8'h05, 16'h00c2, 16'h0180);
        chk({pg, pc}, 24'h004500);
        chk(ps, 16'h00c6);
        chk(sp, 16'h017b);
        st = '{8'h05, 8'h43, 8'h02, 8'h00, 8'hc2};
        for (int k = 0; k < 5; k++) begin
            chk(i_mem.mem[16'h0180 - k], st[k]);
        end
        // Running refuses counter writes; unmapped reads zero
        wreg(4'h2, 16'h1234);
        rreg(4'h2, v);
        chk(v, 16'h4500);
        rreg(4'hf, v);
        chk(v, 16'h0000);
        chk(hl, 1'b0);
        give_verdict();
    end
endmodule
`default_nettype wire
